/* File: rtl/flash_cmd_ctl.sv */
// Command-state logic of a serial NOR flash: suspend/resume, software reset, OTP area.
// Assumes mode-0 SPI from an outside controller; pins are sampled on ref_clk.
// Contract
// [R1] Reads to the suspended page return indeterminate data during program suspend.
// [R2] Volatile and enhanced volatile config writes accepted in program suspend.
// [R3] Resumed erase ignores lock bits changed during the suspend.
// [R4] One nesting level; first resume restarts program, second restarts erase.
// [R5] Host waits before suspending; device does not enforce it.
// [R6] Erase suspend rejects erases, status/nonvolatile writes and OTP program.
// [R7] Suspend accepted only while program or erase runs.
// [R8] While busy only status reads and suspend are accepted; the device also takes the reset pair and serves OTP reads.
// [R9] Erase suspend allows page program outside suspended sector, never OTP.
// [R10] Sector and subsector erase only in standby.
// [R11] Status write, nonvolatile write, OTP program, bulk erase only in standby.
// [R12] Enable, flag clear, address, lock, config writes: standby or suspended.
// [R13] Resume sets write-in-progress, clears controller-ready; ignored if nothing suspended.
// [R14] Reset needs enable 66h then memory 99h, no address bytes.
// [R15] Host keeps deselect gaps around the reset; not enforced.
// [R16] Both reset commands then chip select rising gives power-on reset.
// [R17] Software reset aborts running or suspended operations.
// [R18] Reset restores lock bits, volatile regs and extended address from nonvolatile; only vcr loads nv_config, the rest load fixed defaults.
// [R19] OTP read samples on rising edges, shifts data on falling edges, increments.
// [R20] OTP read does not wrap; last location repeats until deselect.
// [R21] OTP program ignored without write-enable; flag errors unchanged.
// [R22] OTP program latches at most 65 bytes; deselect starts timed program.
// [R23] Locked OTP ignores program, keeps write-enable, sets flag bits 1 and 4.
// [R24] Program suspend sets bit 2, erase suspend bit 6, bit 7 after latency.
// [R25] Any command between reset enable and reset memory cancels the reset.
`default_nettype none
module flash_cmd_ctl
	import flash_ctl_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Serial pins
	input wire logic serial_clk,
	input wire logic chip_sel_n,
	input wire logic serial_in_line,
	output logic serial_out_line,
	output logic serial_out_oe,
	// Nonvolatile defaults
	input wire logic [7:0] nv_config,
	// Status
	output logic [7:0] status_reg,
	output logic [7:0] flag_status,
	output logic [7:0] vcr,
	output logic [7:0] evcr,
	output logic [7:0] ext_addr,
	output logic [7:0] lock_bits,
	output logic soft_reset_pulse,
	output logic rd_garbage
);
	typedef enum {ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA} ph_t;

	// Pin synchronisers
	logic [1:0] sclk_s_r, cs_s_r, din_s_r;
	logic sclk_d_r;
	always_ff @(posedge ref_clk) begin
		sclk_s_r <= {sclk_s_r[0], serial_clk};
		cs_s_r <= {cs_s_r[0], chip_sel_n};
		din_s_r <= {din_s_r[0], serial_in_line};
		sclk_d_r <= sclk_s_r[1];
	end
	wire logic sclk_rise = sclk_s_r[1] & ~sclk_d_r;
	wire logic sclk_fall = ~sclk_s_r[1] & sclk_d_r;
	wire logic cs_n = cs_s_r[1];
	wire logic din = din_s_r[1];
	logic cs_d_r;
	always_ff @(posedge ref_clk) begin
		cs_d_r <= cs_n;
	end
	wire logic cs_rise = cs_n & ~cs_d_r;

	// Command frame state
	ph_t ph_r;
	logic [7:0] cmd_r, sh_r;
	logic [2:0] bit_r;
	logic [4:0] abit_r;
	logic [ADDR_W-1:0] addr_r;
	logic [OTP_AW-1:0] otp_ptr_r, otp_cnt_r;
	logic [3:0] dum_r;
	logic cmd_done_r;

	// Operation state
	op_desc_t run_r, prog_sus_r, erase_sus_r;
	logic running_r, sus_pending_r;
	logic [12:0] op_cnt_r;
	logic [10:0] lat_cnt_r;
	logic wel_r, rst_armed_r;
	logic [7:0] fs_r;
	vol_regs_t vol_r;
	logic [7:0] otp_buf_r [0:64];
	logic [7:0] otp_rd;
	logic [OTP_AW-1:0] pg_idx_r;
	logic otp_locked_r;

	wire logic prog_sus = prog_sus_r.kind != OP_NONE;
	wire logic erase_sus = erase_sus_r.kind != OP_NONE;
	wire logic any_sus = prog_sus | erase_sus;
	wire logic busy = running_r | sus_pending_r;

	function automatic logic is_status_rd(input logic [7:0] c);
		return c == CMD_RDSR || c == CMD_RDFSR;
	endfunction : is_status_rd
	function automatic logic is_vol_write(input logic [7:0] c);
		return c == CMD_WREN || c == CMD_WRDI || c == CMD_CLFSR || c == CMD_WREAR ||
			c == CMD_WRLR || c == CMD_EN4B || c == CMD_EX4B || c == CMD_WRVCR ||
			c == CMD_WREVCR;
	endfunction : is_vol_write
	function automatic logic has_addr(input logic [7:0] c);
		return c == CMD_READ || c == CMD_PP || c == CMD_SE || c == CMD_SSE ||
			c == CMD_OTP_RD || c == CMD_OTP_PG;
	endfunction : has_addr

	// Acceptance decode per device state
	wire logic in_sus_sector = erase_sus &&
		addr_r[ADDR_W-1:SECT_LSB] == erase_sus_r.addr[ADDR_W-1:SECT_LSB];
	wire logic in_sus_page = prog_sus &&
		addr_r[ADDR_W-1:PAGE_LSB] == prog_sus_r.addr[ADDR_W-1:PAGE_LSB];
	wire logic standby_only = cmd_r == CMD_SE || cmd_r == CMD_SSE || cmd_r == CMD_BE ||
		cmd_r == CMD_WRSR || cmd_r == CMD_WRNVCR || cmd_r == CMD_OTP_PG; // R10 R11
	wire logic accept_busy = is_status_rd(cmd_r) || cmd_r == CMD_SUSP; // R8
	wire logic accept_prog = !prog_sus && !in_sus_sector; // R9
	logic accept;
	always_comb begin
		accept = 1'b0;
		if (busy) begin
			accept = accept_busy; // R8
		end else if (standby_only) begin
			accept = !any_sus; // R6 R10 R11
		end else if (cmd_r == CMD_PP) begin
			accept = accept_prog; // R9
		end else if (cmd_r == CMD_SUSP) begin
			accept = 1'b0; // R7
		end else begin
			accept = 1'b1; // R2 R12
		end
	end
	assign rd_garbage = ph_r == ST_DATA && cmd_r == CMD_READ && (in_sus_page || in_sus_sector); // R1

	// Serial front end
	always_ff @(posedge ref_clk) begin
		if (reset || cs_n) begin
			ph_r <= cs_n ? ST_IDLE : ST_CMD;
			bit_r <= 3'h0;
			abit_r <= 5'h0;
			dum_r <= 4'h0;
			otp_cnt_r <= '0;
			if (reset) begin
				cmd_r <= 8'h00;
				cmd_done_r <= 1'b0;
			end
		end else begin
			if (ph_r == ST_IDLE) begin
				ph_r <= ST_CMD;
				cmd_done_r <= 1'b0;
			end
			if (sclk_rise) begin
				sh_r <= {sh_r[6:0], din};
				bit_r <= bit_r + 3'h1;
				case (ph_r)
					ST_CMD: begin
						if (bit_r == 3'h7) begin
							cmd_r <= {sh_r[6:0], din};
							cmd_done_r <= 1'b1;
							ph_r <= has_addr({sh_r[6:0], din}) ? ST_ADDR : ST_DATA;
							// Bytes the host never sends must program as erased
							if ({sh_r[6:0], din} == CMD_OTP_PG && !busy) begin
								for (int i = 0; i <= OTP_CTRL_ADDR; i++) begin
									otp_buf_r[i] <= OTP_ERASED;
								end
							end
						end
					end
					ST_ADDR: begin
						addr_r <= {addr_r[ADDR_W-2:0], din};
						abit_r <= abit_r + 5'h1;
						if (abit_r == 5'(ADDR_W - 1)) begin
							ph_r <= cmd_r == CMD_OTP_RD ? ST_DUMMY : ST_DATA;
							bit_r <= 3'h0;
							otp_ptr_r <= {addr_r[5:0], din}; // R19
						end
					end
					ST_DUMMY: begin
						dum_r <= dum_r + 4'h1;
						bit_r <= 3'h0;
						if (dum_r == 4'(OTP_DUMMY - 1)) begin
							ph_r <= ST_DATA;
						end
					end
					ST_DATA: begin
						if (bit_r == 3'h7 && cmd_r == CMD_OTP_PG && !busy) begin
							if (otp_cnt_r != OTP_MAX_BYTES) begin // R22
								otp_buf_r[otp_ptr_r + otp_cnt_r] <= {sh_r[6:0], din};
								otp_cnt_r <= otp_cnt_r + 7'h1;
							end
						end
						if (bit_r == 3'h7 && cmd_r == CMD_OTP_RD && otp_ptr_r != OTP_LAST) begin
							otp_ptr_r <= otp_ptr_r + 7'h1; // R19 R20
						end
					end
					default: ;
				endcase
			end
		end
	end

	// OTP data out on falling edges
	logic [7:0] out_sh_r;
	logic otp_out_r;
	always_ff @(posedge ref_clk) begin
		if (reset || cs_n) begin
			otp_out_r <= 1'b0;
			serial_out_line <= 1'b0;
			out_sh_r <= 8'h00;
		end else if (sclk_fall && ph_r == ST_DATA && cmd_r == CMD_OTP_RD) begin
			otp_out_r <= 1'b1;
			serial_out_line <= bit_r == 3'h0 ? otp_rd[7] : out_sh_r[7]; // R19
			out_sh_r <= bit_r == 3'h0 ? {otp_rd[6:0], 1'b0} : {out_sh_r[6:0], 1'b0};
		end
	end
	assign serial_out_oe = otp_out_r & ~cs_n;

	// OTP store writes the buffer one byte per cycle after deselect
	logic otp_wr;
	assign otp_wr = running_r && run_r.kind == OP_OTP && pg_idx_r <= OTP_CTRL_ADDR;
	otp_store i_otp_store (
		.ref_clk(ref_clk),
		.reset(reset),
		.wr_en(otp_wr),
		.wr_addr(pg_idx_r),
		.wr_data(otp_buf_r[pg_idx_r]),
		.rd_addr(otp_ptr_r),
		.rd_data(otp_rd)
	);

	// Command execution at chip select rising
	wire logic exec = cs_rise && cmd_done_r;
	wire logic do_reset = exec && cmd_r == CMD_RST_MEM && rst_armed_r; // R14 R16 R25
	assign soft_reset_pulse = do_reset;
	wire logic susp_ok = exec && cmd_r == CMD_SUSP && running_r && !sus_pending_r; // R7
	wire logic resume_ok = exec && cmd_r == CMD_RESUME && !busy && any_sus; // R13
	wire logic start_ok = exec && accept && wel_r &&
		(cmd_r == CMD_PP || cmd_r == CMD_SE || cmd_r == CMD_SSE || cmd_r == CMD_BE);
	wire logic otp_go = exec && accept && cmd_r == CMD_OTP_PG && wel_r; // R21

	always_ff @(posedge ref_clk) begin
		if (reset || do_reset) begin // R16 R17 R18
			running_r <= 1'b0;
			sus_pending_r <= 1'b0;
			run_r <= '{OP_NONE, '0};
			prog_sus_r <= '{OP_NONE, '0};
			erase_sus_r <= '{OP_NONE, '0};
			wel_r <= 1'b0;
			fs_r <= FS_RESET;
			rst_armed_r <= 1'b0;
			vol_r <= '{nv_config, VCR_DEF, 8'h00, LOCK_DEF}; // R18
			op_cnt_r <= '0;
			lat_cnt_r <= '0;
			pg_idx_r <= '0;
			if (reset) otp_locked_r <= 1'b0; // R23
		end else begin
			if (exec) begin
				rst_armed_r <= cmd_r == CMD_RST_EN; // R14 R25
			end
			if (exec && accept && !busy) begin
				if (cmd_r == CMD_WREN) wel_r <= 1'b1;
				if (cmd_r == CMD_WRDI) wel_r <= 1'b0;
				if (cmd_r == CMD_CLFSR) fs_r[FS_ERA_ERR:FS_PGM_ERR] <= 2'h0; // R12
				if (cmd_r == CMD_CLFSR) fs_r[FS_PE_ERR] <= 1'b0; // R12
				if (cmd_r == CMD_WRVCR) vol_r.vcr <= sh_r; // R2
				if (cmd_r == CMD_WREVCR) vol_r.evcr <= sh_r; // R2
				if (cmd_r == CMD_WREAR) vol_r.ext_addr <= sh_r; // R12
				if (cmd_r == CMD_WRLR) vol_r.lock <= sh_r; // R12
			end
			if (start_ok) begin
				running_r <= 1'b1;
				wel_r <= 1'b0;
				op_cnt_r <= 13'(OP_CYC);
				run_r <= '{cmd_r == CMD_PP ? OP_PROG : OP_ERASE, addr_r};
				fs_r[FS_READY] <= 1'b0;
			end
			if (otp_go && otp_locked_r) begin
				fs_r[FS_PE_ERR] <= 1'b1; // R23
				fs_r[FS_PGM_ERR] <= 1'b1; // R23
			end else if (otp_go) begin // R22
				running_r <= 1'b1;
				wel_r <= 1'b0;
				op_cnt_r <= 13'(OTP_PGM_CYC);
				pg_idx_r <= '0;
				run_r <= '{OP_OTP, '0};
				fs_r[FS_READY] <= 1'b0;
			end
			if (susp_ok && run_r.kind != OP_OTP) begin // R24
				sus_pending_r <= 1'b1;
				lat_cnt_r <= 11'(SUSP_LAT_CYC);
				fs_r[run_r.kind == OP_PROG ? FS_PSUS : FS_ESUS] <= 1'b1;
			end
			if (resume_ok) begin // R4 R13
				fs_r[FS_READY] <= 1'b0;
				running_r <= 1'b1;
				op_cnt_r <= 13'(OP_CYC);
				if (prog_sus) begin
					run_r <= prog_sus_r;
					prog_sus_r <= '{OP_NONE, '0};
					fs_r[FS_PSUS] <= 1'b0;
				end else begin
					run_r <= erase_sus_r; // R3
					erase_sus_r <= '{OP_NONE, '0};
					fs_r[FS_ESUS] <= 1'b0;
				end
			end
			if (running_r && run_r.kind == OP_OTP && pg_idx_r <= OTP_CTRL_ADDR) begin
				pg_idx_r <= pg_idx_r + 7'h1;
				if (pg_idx_r == OTP_CTRL_ADDR && !otp_buf_r[OTP_CTRL_ADDR][0]) begin
					otp_locked_r <= 1'b1; // R23
				end
			end
			if (sus_pending_r) begin
				lat_cnt_r <= lat_cnt_r - 11'h1;
				if (lat_cnt_r == 11'h1) begin // R24
					sus_pending_r <= 1'b0;
					running_r <= 1'b0;
					fs_r[FS_READY] <= 1'b1;
					if (run_r.kind == OP_PROG) prog_sus_r <= run_r;
					else erase_sus_r <= run_r;
					run_r <= '{OP_NONE, '0};
				end
			end else if (running_r && !start_ok && !otp_go && !resume_ok) begin
				op_cnt_r <= op_cnt_r - 13'h1;
				if (op_cnt_r == 13'h1) begin
					running_r <= 1'b0;
					fs_r[FS_READY] <= 1'b1;
					run_r <= '{OP_NONE, '0};
				end
			end
		end
	end

	assign status_reg = {6'h00, wel_r, running_r | sus_pending_r}; // R13
	assign flag_status = fs_r;
	assign vcr = vol_r.vcr;
	assign evcr = vol_r.evcr;
	assign ext_addr = vol_r.ext_addr;
	assign lock_bits = vol_r.lock;

	a_resume_wip: assert property (@(posedge ref_clk) disable iff (reset) // R13
		resume_ok |=> status_reg[0] && !flag_status[FS_READY]) else $error("resume bits");
	a_susp_ignored: assert property (@(posedge ref_clk) disable iff (reset) // R7
		(exec && cmd_r == CMD_SUSP && !running_r) |=> !sus_pending_r) else $error("suspend");
	a_reset_clears: assert property (@(posedge ref_clk) disable iff (reset) // R17
		do_reset |=> !any_sus && !running_r && vcr == nv_config) else $error("reset");
	a_busy_reject: assert property (@(posedge ref_clk) disable iff (reset) // R8
		(busy && cmd_r == CMD_WREN) |-> !accept) else $error("busy accept");
	a_esus_reject: assert property (@(posedge ref_clk) disable iff (reset) // R6
		(erase_sus && cmd_r == CMD_OTP_PG) |-> !accept) else $error("esus accept");
	a_otp_nowel: assert property (@(posedge ref_clk) disable iff (reset) // R21
		(exec && cmd_r == CMD_OTP_PG && !wel_r) |=> $stable(fs_r[FS_PGM_ERR])) else $error("wel");
	a_susp_flag: assert property (@(posedge ref_clk) disable iff (reset) // R24
		(susp_ok && run_r.kind == OP_PROG) |=> flag_status[FS_PSUS]) else $error("psus");
	a_otp_nowrap: assert property (@(posedge ref_clk) disable iff (reset) // R20
		(otp_ptr_r == OTP_LAST && ph_r == ST_DATA && cmd_r == CMD_OTP_RD) |=>
		otp_ptr_r == OTP_LAST) else $error("wrap");
endmodule : flash_cmd_ctl
`default_nettype wire

/* File: rtl/flash_ctl_pkg.sv */
// Constants, command codes and carrier types for the serial flash command-state block.
// Assumes one 100 MHz system clock; the serial link is sampled, not used as a clock.
`default_nettype none
package flash_ctl_pkg;
	// Command codes (standard serial flash opcodes)
	localparam logic [7:0] CMD_WREN = 8'h06;
	localparam logic [7:0] CMD_WRDI = 8'h04;
	localparam logic [7:0] CMD_RDSR = 8'h05;
	localparam logic [7:0] CMD_RDFSR = 8'h70;
	localparam logic [7:0] CMD_CLFSR = 8'h50;
	localparam logic [7:0] CMD_WRSR = 8'h01;
	localparam logic [7:0] CMD_WRNVCR = 8'hb1;
	localparam logic [7:0] CMD_WRVCR = 8'h81;
	localparam logic [7:0] CMD_WREVCR = 8'h61;
	localparam logic [7:0] CMD_WREAR = 8'hc5;
	localparam logic [7:0] CMD_WRLR = 8'he5;
	localparam logic [7:0] CMD_EN4B = 8'hb7;
	localparam logic [7:0] CMD_EX4B = 8'he9;
	localparam logic [7:0] CMD_READ = 8'h03;
	localparam logic [7:0] CMD_PP = 8'h02;
	localparam logic [7:0] CMD_SE = 8'hd8;
	localparam logic [7:0] CMD_SSE = 8'h20;
	localparam logic [7:0] CMD_BE = 8'hc7;
	localparam logic [7:0] CMD_SUSP = 8'h75;
	localparam logic [7:0] CMD_RESUME = 8'h7a;
	localparam logic [7:0] CMD_RST_EN = 8'h66;
	localparam logic [7:0] CMD_RST_MEM = 8'h99;
	localparam logic [7:0] CMD_OTP_RD = 8'h4b;
	localparam logic [7:0] CMD_OTP_PG = 8'h42;
	// Widths and positions
	localparam int ADDR_W = 24;
	localparam int OTP_AW = 7;
	localparam logic [6:0] OTP_LAST = 7'h40;
	localparam logic [6:0] OTP_CTRL_ADDR = 7'h40;
	localparam logic [6:0] OTP_MAX_BYTES = 7'h41;
	localparam logic [7:0] OTP_ERASED = 8'hff;
	localparam int OTP_DUMMY = 8;
	localparam int PAGE_LSB = 8;
	localparam int SECT_LSB = 16;
	localparam int FS_PE_ERR = 1;
	localparam int FS_PSUS = 2;
	localparam int FS_PGM_ERR = 4;
	localparam int FS_ERA_ERR = 5;
	localparam int FS_ESUS = 6;
	localparam int FS_READY = 7;
	localparam logic [7:0] FS_RESET = 8'h80;
	localparam logic [7:0] VCR_DEF = 8'hfb;
	localparam logic [7:0] LOCK_DEF = 8'h00;
	// Timing
	localparam int CLK_MHZ = 100;
	localparam int SUSP_LAT_US = 15;
	localparam int SUSP_LAT_CYC = SUSP_LAT_US * CLK_MHZ;
	localparam int OP_TIME_US = 50;
	localparam int OP_CYC = OP_TIME_US * CLK_MHZ;
	localparam int OTP_PGM_US = 20;
	localparam int OTP_PGM_CYC = OTP_PGM_US * CLK_MHZ;
	typedef enum logic [1:0] {OP_NONE, OP_PROG, OP_ERASE, OP_OTP} op_kind_t;
	typedef struct packed {
		op_kind_t kind;
		logic [ADDR_W-1:0] addr;
	} op_desc_t;
	typedef struct packed {
		logic [7:0] vcr;
		logic [7:0] evcr;
		logic [7:0] ext_addr;
		logic [7:0] lock;
	} vol_regs_t;
endpackage : flash_ctl_pkg
`default_nettype wire

/* File: rtl/otp_store.sv */
// OTP byte store: 65 bytes, registered read port, one write port.
// Assumes writes only come from the program engine of the command block.
`default_nettype none
module otp_store
	import flash_ctl_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Write port
	input wire logic wr_en,
	input wire logic [OTP_AW-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	// Read port
	input wire logic [OTP_AW-1:0] rd_addr,
	output logic [7:0] rd_data
);
	logic [7:0] mem_r [0:64];

	// Programming only clears bits, as a flash cell does.
	// A hard reset stands for a fresh part and erases the cells; a soft reset never reaches here.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			for (int i = 0; i <= OTP_CTRL_ADDR; i++) begin
				mem_r[i] <= OTP_ERASED;
			end
		end else if (wr_en) begin
			mem_r[wr_addr] <= mem_r[wr_addr] & wr_data;
		end
		rd_data <= mem_r[rd_addr];
	end
endmodule : otp_store
`default_nettype wire

/* File: verification/spi_host.sv */
// Serial bus host model: drives mode-0 frames into the flash command block.
// Assumes the bench's 100 MHz ref_clk; every pin moves on its falling edge.
`default_nettype none
module spi_host (
	// Clock
	input wire logic ref_clk,
	// Device side
	input wire logic serial_out_line,
	input wire logic serial_out_oe,
	output logic serial_clk,
	output logic chip_sel_n,
	output logic serial_in_line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] tx [0:79];
	logic [7:0] rx [0:7];
	int oe_bad = 0;
	initial begin
		// Link clock stands still between frames
		serial_clk = 1'b0;
		chip_sel_n = 1'b1;
		serial_in_line = 1'b0;
	end
	// 40 ns half period of the 80 ns link clock
	task automatic half();
		repeat (4) @(negedge ref_clk);
	endtask : half
	task automatic frame(input int ntx, input int nrx);
		int i;
		int k;
		@(negedge ref_clk);
		chip_sel_n = 1'b0;
		half();
		for (i = 0; i < ntx + nrx; i++) begin
			for (k = 7; k >= 0; k--) begin
				// Unused input toggles so a stale level never passes for data
				serial_in_line = (i < ntx) ? tx[i][k] : ~serial_in_line;
				half();
				serial_clk = 1'b1;
				// Read bit stands falling to falling; sample late in the bit
				repeat (3) @(negedge ref_clk);
				if (i >= ntx) begin
					rx[i-ntx][k] = serial_out_line;
					if (serial_out_oe !== 1'b1) oe_bad++;
				end
				@(negedge ref_clk);
				serial_clk = 1'b0;
			end
		end
		half();
		chip_sel_n = 1'b1;
		serial_in_line = ~serial_in_line;
		// Deselect gap also covers the spacing around a software reset
		repeat (8) half();
	endtask : frame
endmodule : spi_host
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the flash command block and its host model.
// Assumes the package constants; nv_config is held at one fixed value.
`default_nettype none
module tb
	import flash_ctl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] NV = 8'h5a;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	wire serial_clk;
	wire chip_sel_n;
	wire serial_in_line;
	logic serial_out_line, serial_out_oe, soft_reset_pulse, rd_garbage;
	logic [7:0] status_reg, flag_status, vcr, evcr, ext_addr, lock_bits;
	int fail_count = 0;
	int num_checks = 0;
	int pulses = 0;
	int garb = 0;
	initial forever #5 ref_clk = ~ref_clk;
	flash_cmd_ctl i_flash_cmd_ctl (.ref_clk(ref_clk), .reset(reset),
		.serial_clk(serial_clk), .chip_sel_n(chip_sel_n), .serial_in_line(serial_in_line),
		.serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe), .nv_config(NV),
		.status_reg(status_reg), .flag_status(flag_status), .vcr(vcr), .evcr(evcr),
		.ext_addr(ext_addr), .lock_bits(lock_bits), .soft_reset_pulse(soft_reset_pulse),
		.rd_garbage(rd_garbage));
	spi_host host (.ref_clk(ref_clk), .serial_out_line(serial_out_line),
		.serial_out_oe(serial_out_oe), .serial_clk(serial_clk), .chip_sel_n(chip_sel_n),
		.serial_in_line(serial_in_line));
	always @(posedge ref_clk) begin
		if (soft_reset_pulse === 1'b1) pulses++;
		if (rd_garbage === 1'b1) garb++;
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic cb(input string what, input logic seen, input logic exp);
		chk(what, {7'h00, seen}, {7'h00, exp});
	endtask : cb
	// Bounded poll on one status or flag bit
	task automatic wait_bit(input int b, input logic v, input int lim, input logic fs);
		int n;
		for (n = 0; n < lim; n++) begin
			@(negedge ref_clk);
			if ((fs ? flag_status[b] : status_reg[b]) === v) return;
		end
		fail_count++;
		$display("BAD wait_bit expected %h seen timeout", v);
		give_verdict();
	endtask : wait_bit
	task automatic s1(input logic [7:0] c);
		host.tx[0] = c;
		host.frame(1, 0);
	endtask : s1
	// Write-enabled one-byte register write
	task automatic w2(input logic [7:0] c, input logic [7:0] d);
		s1(CMD_WREN);
		host.tx[0] = c;
		host.tx[1] = d;
		host.frame(2, 0);
	endtask : w2
	// Data bytes beyond the address sit in tx[4] onwards
	task automatic sa(input logic [7:0] c, input logic [23:0] a, input int nd, input int nr);
		host.tx[0] = c;
		host.tx[1] = a[23:16];
		host.tx[2] = a[15:8];
		host.tx[3] = a[7:0];
		host.frame(4 + nd, nr);
	endtask : sa
	task automatic sd(input logic [7:0] c, input logic [23:0] a, input logic [7:0] d);
		host.tx[4] = d;
		sa(c, a, 1, 0);
	endtask : sd
	task automatic t_standby();
		chk("flags", flag_status, FS_RESET);
		chk("vcr", vcr, NV);
		s1(CMD_SUSP);
		chk("flags", flag_status, FS_RESET);
		s1(CMD_RESUME);
		cb("wip", status_reg[0], 1'b0);
		s1(CMD_WREN);
		cb("wel", status_reg[1], 1'b1);
		s1(CMD_WRDI);
		cb("wel", status_reg[1], 1'b0);
		w2(CMD_WREAR, 8'h3c);
		chk("ext", ext_addr, 8'h3c);
		w2(CMD_WREVCR, 8'h12);
		chk("evcr", evcr, 8'h12);
		$display("standby test done");
	endtask : t_standby
	task automatic t_prog();
		s1(CMD_WREN);
		sd(CMD_PP, 24'h001234, 8'ha5);
		cb("wip", status_reg[0], 1'b1);
		w2(CMD_WRVCR, 8'h33);
		cb("wel", status_reg[1], 1'b0);
		chk("vcr", vcr, NV);
		// Suspend spacing scaled down with the shortened operation time
		repeat (100) @(negedge ref_clk);
		s1(CMD_SUSP);
		cb("psus", flag_status[FS_PSUS], 1'b1);
		cb("ready", flag_status[FS_READY], 1'b0);
		wait_bit(FS_READY, 1'b1, 1600, 1'b1);
		w2(CMD_WRVCR, 8'h33);
		chk("vcr", vcr, 8'h33);
		garb = 0;
		sa(CMD_READ, 24'h0012f0, 0, 1);
		cb("garbage", garb != 0, 1'b1);
		garb = 0;
		sa(CMD_READ, 24'h001300, 0, 1);
		cb("garbage", garb != 0, 1'b0);
		s1(CMD_RESUME);
		cb("wip", status_reg[0], 1'b1);
		cb("ready", flag_status[FS_READY], 1'b0);
		wait_bit(0, 1'b0, 6000, 1'b0);
		$display("program suspend test done");
	endtask : t_prog
	task automatic t_erase();
		s1(CMD_WREN);
		sa(CMD_SE, 24'h010000, 0, 0);
		cb("wip", status_reg[0], 1'b1);
		repeat (100) @(negedge ref_clk);
		s1(CMD_SUSP);
		cb("esus", flag_status[FS_ESUS], 1'b1);
		wait_bit(FS_READY, 1'b1, 1600, 1'b1);
		s1(CMD_WREN);
		cb("wel", status_reg[1], 1'b1);
		sa(CMD_SSE, 24'h020000, 0, 0);
		cb("wip", status_reg[0], 1'b0);
		s1(CMD_BE);
		cb("wip", status_reg[0], 1'b0);
		sd(CMD_OTP_PG, 24'h000000, 8'h00);
		cb("wip", status_reg[0], 1'b0);
		sd(CMD_PP, 24'h010010, 8'h5a);
		cb("wip", status_reg[0], 1'b0);
		sd(CMD_PP, 24'h000100, 8'h5a);
		cb("wip", status_reg[0], 1'b1);
		repeat (100) @(negedge ref_clk);
		s1(CMD_SUSP);
		cb("psus", flag_status[FS_PSUS], 1'b1);
		cb("esus", flag_status[FS_ESUS], 1'b1);
		wait_bit(FS_READY, 1'b1, 1600, 1'b1);
		s1(CMD_RESUME);
		cb("esus", flag_status[FS_ESUS], 1'b1);
		wait_bit(0, 1'b0, 6000, 1'b0);
		s1(CMD_RESUME);
		cb("wip", status_reg[0], 1'b1);
		s1(CMD_RST_EN);
		s1(CMD_RST_MEM);
		cb("wip", status_reg[0], 1'b0);
		chk("flags", flag_status, FS_RESET);
		$display("erase nesting test done");
	endtask : t_erase
	task automatic t_reset();
		w2(CMD_WRVCR, 8'h33);
		w2(CMD_WREAR, 8'h3c);
		w2(CMD_WRLR, 8'h01);
		chk("lock", lock_bits, 8'h01);
		pulses = 0;
		s1(CMD_RST_EN);
		s1(CMD_WREN);
		s1(CMD_RST_MEM);
		chk("pulses", 8'(pulses), 8'h00);
		chk("vcr", vcr, 8'h33);
		s1(CMD_RST_EN);
		s1(CMD_RST_MEM);
		chk("pulses", 8'(pulses), 8'h01);
		chk("status", status_reg, 8'h00);
		chk("vcr", vcr, NV);
		chk("ext", ext_addr, 8'h00);
		chk("lock", lock_bits, LOCK_DEF);
		$display("software reset test done");
	endtask : t_reset
	task automatic t_otp();
		int i;
		sd(CMD_OTP_PG, 24'h00003e, 8'h11);
		cb("wip", status_reg[0], 1'b0);
		chk("flags", flag_status, FS_RESET);
		s1(CMD_WREN);
		host.tx[4] = 8'h11;
		host.tx[5] = 8'h22;
		sa(CMD_OTP_PG, 24'h00003e, 2, 0);
		cb("wip", status_reg[0], 1'b1);
		wait_bit(0, 1'b0, 2500, 1'b0);
		host.tx[4] = 8'h00;
		host.oe_bad = 0;
		sa(CMD_OTP_RD, 24'h00003e, 1, 3);
		chk("otp0", host.rx[0], 8'h11);
		chk("otp1", host.rx[1], 8'h22);
		chk("otp2", host.rx[2], OTP_ERASED);
		s1(CMD_WREN);
		sd(CMD_OTP_PG, {17'h0, OTP_CTRL_ADDR}, 8'hfe);
		wait_bit(0, 1'b0, 2500, 1'b0);
		host.tx[4] = 8'h00;
		sa(CMD_OTP_RD, 24'h00003f, 1, 4);
		chk("otp_lo", host.rx[0], 8'h22);
		for (i = 1; i < 4; i++) begin
			chk("otp_last", host.rx[i], 8'hfe);
		end
		chk("oe", 8'(host.oe_bad), 8'h00);
		s1(CMD_WREN);
		sd(CMD_OTP_PG, 24'h000000, 8'h55);
		chk("status", status_reg, 8'h02);
		cb("perr", flag_status[FS_PE_ERR], 1'b1);
		cb("pgmerr", flag_status[FS_PGM_ERR], 1'b1);
		s1(CMD_CLFSR);
		chk("flags", flag_status, FS_RESET);
		$display("otp test done");
	endtask : t_otp
	initial begin
		repeat (6) @(negedge ref_clk);
		reset = 1'b0;
		repeat (2) @(negedge ref_clk);
		t_standby();
		t_prog();
		t_erase();
		t_reset();
		t_otp();
		give_verdict();
	end
endmodule : tb
`default_nettype wire
